// file: occg_clk_gate.sv
// Glitch-free peripheral clock enables, changed only at clock edges
`timescale 1ns/1ps
module occg_clk_gate #(
  parameter int WIDTH = 11
) (
  input wire logic clk_sys, // Bus clock
  input wire logic rst_n, // Synchronised reset
  input wire logic [WIDTH-1:0] gate_req, // Requested enables
  output logic [WIDTH-1:0] gate_en // Registered enables
);

  logic [WIDTH-1:0] next_gate_en;

  // Enable follows the request only at a rising edge
  always_comb
  begin
    next_gate_en = gate_req;
  end

  // Whole pulses only: the enable never moves mid-cycle
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      gate_en <= '0;
    else
      gate_en <= next_gate_en;
  end

endmodule

// file: occg_osc_startup.sv
// Oscillator startup counter driving the init-done status
`timescale 1ns/1ps
module occg_osc_startup #(
  parameter int EDGES = occg_pkg::OSC_STARTUP_EDGES
) (
  input wire logic clk_sys, // Bus clock
  input wire logic rst_n, // Synchronised reset
  input wire logic osc_running, // Oscillator powered
  input wire logic osc_level, // Sampled oscillator output
  output logic init_done // Startup complete
);

  localparam int CW = $clog2(EDGES + 1);
  localparam logic [CW-1:0] LAST = CW'(EDGES);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic prev_level;
  logic next_prev_level;
  logic next_init_done;

  // Count rising oscillator edges while running; drop when stopped
  always_comb
  begin
    next_prev_level = osc_level;
    next_count = count;
    next_init_done = init_done;
    if (!osc_running)
    begin
      next_count = '0;
      next_init_done = 1'b0;
    end
    else if (osc_level && !prev_level && !init_done)
    begin
      next_count = count + CW'(1);
      if (next_count == LAST)
        next_init_done = 1'b1;
    end
  end

  // Counter state
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count <= '0;
      prev_level <= 1'b0;
      init_done <= 1'b0;
    end
    else
    begin
      count <= next_count;
      prev_level <= next_prev_level;
      init_done <= next_init_done;
    end
  end

endmodule

// file: occg_pkg.sv
// Constants, register map and carrier types for the oscillator/gating block
// What this block does
// - Enable bit 7 runs oscillator, offers reference
// - Keep-in-stop bit 5 decides stop behaviour
// - Output select bit 4: pin or oscillator
// - Range bit: 0 low range, 1 high
// - Gain bit 1: 0 low, 1 high
// - Init-done bit 0 reads startup completion
// - Reserved bits read zero, ignore writes
// - Gate register 1 at 300C, reset 61h
// - Gate register 2 at 300D, reset 38h
// - Gate register 3 at 300E, reset 10h
// - Gate register 4 at 300F, reset A9h
// - Gate 1 bit 6 clocks timer B
// - Gate 1 bit 5 clocks timer A
// - Gate 1 bit 0 clocks real-time counter
// - Gate 2 bit 5 clocks debug module
// - Gate 2 bit 4 clocks memory controller
// - Gate 2 bit 3 clocks interrupt priority
// - Gate 3 bit 4 clocks serial port
// - Gate 4 bits 7,5,3,0 clock four peripherals
package occg_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [15:0] IDX_GATE_1 = 16'h300c;
  localparam logic [15:0] IDX_GATE_2 = 16'h300d;
  localparam logic [15:0] IDX_GATE_3 = 16'h300e;
  localparam logic [15:0] IDX_GATE_4 = 16'h300f;
  localparam logic [15:0] IDX_OSC_SC = 16'h303e;
  localparam int BYTE_SHIFT = 2;

  // Reset values
  localparam logic [7:0] RST_GATE_1 = 8'h61;
  localparam logic [7:0] RST_GATE_2 = 8'h38;
  localparam logic [7:0] RST_GATE_3 = 8'h10;
  localparam logic [7:0] RST_GATE_4 = 8'ha9;
  localparam logic [7:0] RST_OSC_SC = 8'h00;

  // Implemented (writable) bits; all others are reserved zero, except oscillator bit 0, which reads init-done
  localparam logic [7:0] MASK_GATE_1 = 8'h61;
  localparam logic [7:0] MASK_GATE_2 = 8'h38;
  localparam logic [7:0] MASK_GATE_3 = 8'h10;
  localparam logic [7:0] MASK_GATE_4 = 8'ha9;
  localparam logic [7:0] MASK_OSC_SC = 8'hb6;

  // Oscillator register fields
  localparam int OSC_EN_BIT = 7;
  localparam int OSC_KEEP_BIT = 5;
  localparam int OSC_SEL_BIT = 4;
  localparam int OSC_RANGE_BIT = 2;
  localparam int OSC_GAIN_BIT = 1;
  localparam int OSC_INIT_BIT = 0;

  // Gate register fields
  localparam int G1_TIMER_B_BIT = 6;
  localparam int G1_TIMER_A_BIT = 5;
  localparam int G1_RTC_BIT = 0;
  localparam int G2_DEBUG_BIT = 5;
  localparam int G2_NVM_BIT = 4;
  localparam int G2_IPC_BIT = 3;
  localparam int G3_SERIAL_BIT = 4;
  localparam int G4_ANALOG_COMPARATOR_GATE_BIT = 7;
  localparam int G4_ADC_BIT = 5;
  localparam int G4_IRQ_BIT = 3;
  localparam int G4_KBD_BIT = 0;

  // Oscillator edges counted before init-done sets
  localparam int OSC_STARTUP_EDGES = 4096;

  // Register select
  typedef enum logic [2:0] {
    OCCG_SEL_NONE, OCCG_SEL_G1, OCCG_SEL_G2, OCCG_SEL_G3, OCCG_SEL_G4,
    OCCG_SEL_OSC
  } occg_sel_t;

  // Peripheral clock enables, one per gated peripheral
  typedef struct packed {
    logic flex_timer_b_gate;
    logic flex_timer_a_gate;
    logic realtime_counter_gate;
    logic debug_module_gate;
    logic nonvolatile_ctrl_gate;
    logic interrupt_priority_gate;
    logic serial_port_a_gate;
    logic analog_comparator_gate;
    logic converter_gate;
    logic ext_irq_gate;
    logic keyboard_interrupt_gate;
  } occg_gates_t;

  // Oscillator analog controls
  typedef struct packed {
    logic crystal_osc_enable;
    logic osc_select;
    logic high_range;
    logic high_gain_select;
  } occg_osc_ctrl_t;

endpackage

// file: occg_top.sv
// Oscillator control/status and peripheral clock gating, Avalon-MM slave
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module occg_top #(
  parameter int ADDR_W = 16,
  parameter int STARTUP_EDGES = occg_pkg::OSC_STARTUP_EDGES
) (
  input wire logic clk_sys, // Bus clock, 40 MHz
  input wire logic nrst, // Async reset, active low
  input wire logic [ADDR_W-1:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  input wire logic stop_mode, // Stop mode active
  input wire logic clock_unit_osc_request, // Clock source unit wants osc
  input wire logic ext_clock_input_pin, // External clock pin level
  input wire logic osc_clock_level, // Oscillator generated clock
  output logic ext_ref_clock_out, // Selected reference clock
  output logic osc_running, // Oscillator powered
  output occg_pkg::occg_osc_ctrl_t osc_ctrl, // Analog controls
  output occg_pkg::occg_gates_t gates // Peripheral clock enables
);

  // Reset synchroniser
  logic rst_q1;
  logic rst_n;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // Byte address to register select
  function automatic occg_pkg::occg_sel_t decode(
    input logic [ADDR_W-1:0] addr
  );
    logic [ADDR_W-1:0] idx;
    idx = addr >> occg_pkg::BYTE_SHIFT;
    decode = occg_pkg::OCCG_SEL_NONE;
    if (addr[occg_pkg::BYTE_SHIFT-1:0] == '0)
    begin
      if (idx == ADDR_W'(occg_pkg::IDX_GATE_1))
        decode = occg_pkg::OCCG_SEL_G1;
      else if (idx == ADDR_W'(occg_pkg::IDX_GATE_2))
        decode = occg_pkg::OCCG_SEL_G2;
      else if (idx == ADDR_W'(occg_pkg::IDX_GATE_3))
        decode = occg_pkg::OCCG_SEL_G3;
      else if (idx == ADDR_W'(occg_pkg::IDX_GATE_4))
        decode = occg_pkg::OCCG_SEL_G4;
      else if (idx == ADDR_W'(occg_pkg::IDX_OSC_SC))
        decode = occg_pkg::OCCG_SEL_OSC;
    end
  endfunction

  // Masked write merge keeping reserved bits at zero
  function automatic logic [7:0] merge(
    input logic [7:0] data,
    input logic [7:0] mask
  );
    merge = data & mask;
  endfunction

  // Bus handshake state
  typedef enum logic [1:0] {BUS_IDLE, BUS_ANSWER, BUS_DONE} bus_st_t;

  bus_st_t bus_st;
  bus_st_t next_bus_st;
  logic next_waitrequest;
  logic [31:0] next_readdata;
  logic commit;
  occg_pkg::occg_sel_t sel;

  // Registers
  logic [7:0] gate_1;
  logic [7:0] gate_2;
  logic [7:0] gate_3;
  logic [7:0] gate_4;
  logic [7:0] osc_sc;
  logic [7:0] next_gate_1;
  logic [7:0] next_gate_2;
  logic [7:0] next_gate_3;
  logic [7:0] next_gate_4;
  logic [7:0] next_osc_sc;
  logic init_done;

  assign sel = decode(avs_address);
  assign commit = avs_write && !avs_waitrequest && avs_byteenable[0];

  // Handshake: one stall cycle, then waitrequest low for one cycle
  always_comb
  begin
    next_bus_st = bus_st;
    next_waitrequest = 1'b1;
    next_readdata = avs_readdata;
    unique case (bus_st)
      BUS_IDLE:
      begin
        if (avs_read || avs_write)
        begin
          next_bus_st = BUS_ANSWER;
          next_waitrequest = 1'b0;
          next_readdata = 32'h0000_0000;
          if (avs_read)
          begin
            unique case (sel)
              occg_pkg::OCCG_SEL_G1: next_readdata[7:0] = gate_1;
              occg_pkg::OCCG_SEL_G2: next_readdata[7:0] = gate_2;
              occg_pkg::OCCG_SEL_G3: next_readdata[7:0] = gate_3;
              occg_pkg::OCCG_SEL_G4: next_readdata[7:0] = gate_4;
              occg_pkg::OCCG_SEL_OSC:
                next_readdata[7:0] = {osc_sc[7:1], init_done};
              occg_pkg::OCCG_SEL_NONE: next_readdata = 32'h0000_0000;
            endcase
          end
        end
      end
      BUS_ANSWER:
      begin
        next_bus_st = BUS_DONE;
      end
      BUS_DONE:
      begin
        next_bus_st = BUS_IDLE;
      end
    endcase
  end

  // Handshake registers
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_st <= BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      bus_st <= next_bus_st;
      avs_waitrequest <= next_waitrequest;
      avs_readdata <= next_readdata;
    end
  end

  // Register writes, taken at the edge where waitrequest is low
  always_comb
  begin
    next_gate_1 = gate_1;
    next_gate_2 = gate_2;
    next_gate_3 = gate_3;
    next_gate_4 = gate_4;
    next_osc_sc = osc_sc;
    if (commit)
    begin
      unique case (sel)
        occg_pkg::OCCG_SEL_G1:
          next_gate_1 = merge(avs_writedata[7:0],
                              occg_pkg::MASK_GATE_1);
        occg_pkg::OCCG_SEL_G2:
          next_gate_2 = merge(avs_writedata[7:0],
                              occg_pkg::MASK_GATE_2);
        occg_pkg::OCCG_SEL_G3:
          next_gate_3 = merge(avs_writedata[7:0],
                              occg_pkg::MASK_GATE_3);
        occg_pkg::OCCG_SEL_G4:
          next_gate_4 = merge(avs_writedata[7:0],
                              occg_pkg::MASK_GATE_4);
        occg_pkg::OCCG_SEL_OSC:
          next_osc_sc = merge(avs_writedata[7:0],
                              occg_pkg::MASK_OSC_SC);
        occg_pkg::OCCG_SEL_NONE: next_osc_sc = osc_sc;
      endcase
    end
  end

  // Register storage with documented reset values
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gate_1 <= occg_pkg::RST_GATE_1;
      gate_2 <= occg_pkg::RST_GATE_2;
      gate_3 <= occg_pkg::RST_GATE_3;
      gate_4 <= occg_pkg::RST_GATE_4;
      osc_sc <= occg_pkg::RST_OSC_SC;
    end
    else
    begin
      gate_1 <= next_gate_1;
      gate_2 <= next_gate_2;
      gate_3 <= next_gate_3;
      gate_4 <= next_gate_4;
      osc_sc <= next_osc_sc;
    end
  end

  // Oscillator run state and stop-mode hold
  logic stop_q;
  logic req_before_stop;
  logic next_req_before_stop;
  logic next_osc_running;
  logic next_ref_clock;
  occg_pkg::occg_osc_ctrl_t next_osc_ctrl;

  // Request is latched while running, frozen during stop
  always_comb
  begin
    next_req_before_stop = req_before_stop;
    if (!stop_mode)
      next_req_before_stop = clock_unit_osc_request;
    next_osc_running = osc_sc[occg_pkg::OSC_EN_BIT];
    if (stop_mode)
      next_osc_running = osc_sc[occg_pkg::OSC_KEEP_BIT] &&
        (osc_sc[occg_pkg::OSC_EN_BIT] || req_before_stop);
    next_osc_ctrl.crystal_osc_enable = next_osc_running;
    next_osc_ctrl.osc_select = osc_sc[occg_pkg::OSC_SEL_BIT];
    next_osc_ctrl.high_range = osc_sc[occg_pkg::OSC_RANGE_BIT];
    next_osc_ctrl.high_gain_select = osc_sc[occg_pkg::OSC_GAIN_BIT];
    next_ref_clock = 1'b0;
    if (osc_running)
      next_ref_clock = osc_sc[occg_pkg::OSC_SEL_BIT] ?
        osc_clock_level : ext_clock_input_pin;
  end

  // Oscillator output registers
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stop_q <= 1'b0;
      req_before_stop <= 1'b0;
      osc_running <= 1'b0;
      osc_ctrl <= '0;
      ext_ref_clock_out <= 1'b0;
    end
    else
    begin
      stop_q <= stop_mode;
      req_before_stop <= next_req_before_stop;
      osc_running <= next_osc_running;
      osc_ctrl <= next_osc_ctrl;
      ext_ref_clock_out <= next_ref_clock;
    end
  end

  // Startup counter for init-done, on the selected source
  occg_osc_startup #(
    .EDGES(STARTUP_EDGES)
  ) u_startup (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .osc_running(osc_running && !stop_q),
    .osc_level(ext_ref_clock_out),
    .init_done(init_done)
  );

  // Gate bits gathered into the peripheral enable carrier
  occg_pkg::occg_gates_t gate_req;

  always_comb
  begin
    gate_req.flex_timer_b_gate = gate_1[occg_pkg::G1_TIMER_B_BIT];
    gate_req.flex_timer_a_gate = gate_1[occg_pkg::G1_TIMER_A_BIT];
    gate_req.realtime_counter_gate = gate_1[occg_pkg::G1_RTC_BIT];
    gate_req.debug_module_gate = gate_2[occg_pkg::G2_DEBUG_BIT];
    gate_req.nonvolatile_ctrl_gate = gate_2[occg_pkg::G2_NVM_BIT];
    gate_req.interrupt_priority_gate = gate_2[occg_pkg::G2_IPC_BIT];
    gate_req.serial_port_a_gate = gate_3[occg_pkg::G3_SERIAL_BIT];
    gate_req.analog_comparator_gate = gate_4[occg_pkg::G4_ANALOG_COMPARATOR_GATE_BIT];
    gate_req.converter_gate = gate_4[occg_pkg::G4_ADC_BIT];
    gate_req.ext_irq_gate = gate_4[occg_pkg::G4_IRQ_BIT];
    gate_req.keyboard_interrupt_gate = gate_4[occg_pkg::G4_KBD_BIT];
  end

  // Enables change only at edges, so no pulse is ever cut short
  occg_clk_gate #(
    .WIDTH($bits(occg_pkg::occg_gates_t))
  ) u_gate (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .gate_req(gate_req),
    .gate_en(gates)
  );

endmodule

// file: occg_top_sva.sv
// Checker of bus, register and clock-enable behaviour
`timescale 1ns/1ps
module occg_top_sva #(
  parameter int ADDR_W = 16,
  parameter int STARTUP_EDGES = occg_pkg::OSC_STARTUP_EDGES
) (
  input wire logic clk_sys, // Bus clock
  input wire logic nrst, // Reset, active low
  input wire logic [ADDR_W-1:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  input wire logic [31:0] avs_readdata, // Read data
  input wire logic avs_waitrequest, // Stall
  input wire logic stop_mode, // Stop mode
  input wire logic clock_unit_osc_request, // Clock unit request
  input wire logic ext_clock_input_pin, // Pin clock
  input wire logic osc_clock_level, // Osc clock
  input wire logic ext_ref_clock_out, // Reference out
  input wire logic osc_running, // Osc powered
  input wire occg_pkg::occg_osc_ctrl_t osc_ctrl, // Analog controls
  input wire occg_pkg::occg_gates_t gates // Clock enables
);
  localparam logic [ADDR_W-1:0] A_G1 = ADDR_W'(16'hc030);
  localparam logic [ADDR_W-1:0] A_G2 = ADDR_W'(16'hc034);
  localparam logic [ADDR_W-1:0] A_G3 = ADDR_W'(16'hc038);
  localparam logic [ADDR_W-1:0] A_G4 = ADDR_W'(16'hc03c);
  localparam logic [ADDR_W-1:0] A_OS = ADDR_W'(16'hc0f8);
  logic [7:0] sh1, sh2, sh3, sh4, sho, rmask;
  logic [3:0] quiet;
  logic wr;
  logic sel_lvl;
  occg_pkg::occg_gates_t g_exp;

  // Accepted writes, selected source and expected enables
  assign wr = !avs_waitrequest && avs_write && avs_byteenable[0];
  // Select taken from the shadow, so it moves at the same edge as the register
  assign sel_lvl = sho[4] ? osc_clock_level : ext_clock_input_pin;
  assign g_exp = occg_pkg::occg_gates_t'({sh1[6], sh1[5], sh1[0], sh2[5],
    sh2[4], sh2[3], sh3[4], sh4[7], sh4[5], sh4[3], sh4[0]});
  assign rmask = (avs_address == A_G1) ? occg_pkg::MASK_GATE_1 :
    (avs_address == A_G2) ? occg_pkg::MASK_GATE_2 :
    (avs_address == A_G3) ? occg_pkg::MASK_GATE_3 :
    (avs_address == A_G4) ? occg_pkg::MASK_GATE_4 :
    (avs_address == A_OS) ? 8'hb7 : 8'h00;

  // Shadow registers and cycles since the last write
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sh1 <= occg_pkg::RST_GATE_1;
      sh2 <= occg_pkg::RST_GATE_2;
      sh3 <= occg_pkg::RST_GATE_3;
      sh4 <= occg_pkg::RST_GATE_4;
      sho <= occg_pkg::RST_OSC_SC;
      quiet <= 4'h0;
    end
    else
    begin
      if (wr && avs_address == A_G1)
        sh1 <= avs_writedata[7:0];
      if (wr && avs_address == A_G2)
        sh2 <= avs_writedata[7:0];
      if (wr && avs_address == A_G3)
        sh3 <= avs_writedata[7:0];
      if (wr && avs_address == A_G4)
        sh4 <= avs_writedata[7:0];
      if (wr && avs_address == A_OS)
        sho <= avs_writedata[7:0];
      if (wr)
        quiet <= 4'h0;
      else if (quiet != 4'hf)
        quiet <= quiet + 4'h1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_answer;
    !avs_waitrequest;
  endsequence
  sequence s_osc_read;
    !avs_waitrequest && avs_read && avs_address == A_OS;
  endsequence

  a_stall_then_idle: assert property (s_answer |=> avs_waitrequest [*2])
    else $error("answer not followed by two busy cycles");
  a_answer_bound: assert property ($rose(avs_read || avs_write) |->
    ##[0:3] s_answer) else $error("request not answered in time");
  a_reserved_zero: assert property (
    s_answer and avs_read |-> (avs_readdata & {24'h0, rmask}) == avs_readdata)
    else $error("reserved read bit set");
  a_gate_map: assert property (
    quiet >= 4'h4 |-> gates == g_exp) else $error("clock enables wrong");
  a_osc_fields: assert property (quiet >= 4'h4 |->
    osc_ctrl.osc_select == sho[4] && osc_ctrl.high_range == sho[2] &&
    osc_ctrl.high_gain_select == sho[1]) else $error("osc fields wrong");
  a_osc_enable: assert property (
    (!stop_mode) [*3] ##0 quiet >= 4'h4 |-> osc_running == sho[7] &&
    osc_ctrl.crystal_osc_enable == osc_running) else $error("enable wrong");
  a_stop_off: assert property (
    stop_mode [*3] ##0 !sho[5] |-> !osc_running)
    else $error("osc running in stop");
  a_stop_keep: assert property (
    stop_mode [*3] ##0 (sho[5] && sho[7] && quiet >= 4'h4) |-> osc_running)
    else $error("osc stopped despite keep");
  a_ref_idle: assert property ((!osc_running) [*3] |-> !ext_ref_clock_out)
    else $error("reference active while off");
  a_ref_select: assert property (
    (osc_running && sel_lvl) [*4] |-> ext_ref_clock_out)
    else $error("reference not from selected source");
  a_init_clear: assert property (
    (!osc_running) [*5] ##0 s_osc_read |-> !avs_readdata[0])
    else $error("init done while off");
endmodule

bind occg_top occg_top_sva #(.ADDR_W(ADDR_W), .STARTUP_EDGES(STARTUP_EDGES))
  i_sva (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .stop_mode(stop_mode),
  .clock_unit_osc_request(clock_unit_osc_request),
  .ext_clock_input_pin(ext_clock_input_pin),
  .osc_clock_level(osc_clock_level), .ext_ref_clock_out(ext_ref_clock_out),
  .osc_running(osc_running), .osc_ctrl(osc_ctrl), .gates(gates));

// file: tb_top.sv
// Self-checking bench for oscillator control and clock gating
`timescale 1ns/1ps
module tb_top;
  localparam logic [15:0] OSC = 16'h303e;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] avs_address = 16'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic stop_mode = 1'b0;
  logic clock_unit_osc_request = 1'b0;
  logic ext_clock_input_pin = 1'b1;
  logic osc_clock_level = 1'b0;
  logic ext_ref_clock_out;
  logic osc_running;
  occg_pkg::occg_osc_ctrl_t osc_ctrl;
  occg_pkg::occg_gates_t gates;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  int seed = 32'heb058fa6;
  logic [7:0] exp_q [$];
  logic [15:0] idx_t [4] = '{16'h300c, 16'h300d, 16'h300e, 16'h300f};
  // Reset values; every implemented bit resets to one
  logic [7:0] rst_t [4] = '{8'h61, 8'h38, 8'h10, 8'ha9};
  logic [7:0] reg_v [4];

  occg_top #(.STARTUP_EDGES(4)) i_dut (.clk_sys(clk_sys), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .stop_mode(stop_mode), .clock_unit_osc_request(clock_unit_osc_request),
    .ext_clock_input_pin(ext_clock_input_pin),
    .osc_clock_level(osc_clock_level), .ext_ref_clock_out(ext_ref_clock_out),
    .osc_running(osc_running), .osc_ctrl(osc_ctrl), .gates(gates));

  // Bus clock
  always #12.5 clk_sys = ~clk_sys;

  // Source clocks in opposite phase, and the hang limit
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles % 4 == 0)
    begin
      osc_clock_level <= ~osc_clock_level;
      ext_clock_input_pin <= osc_clock_level;
    end
    if (cycles == 6000)
    begin
      fail_count++;
      conclude();
    end
  end

  task automatic conclude();
    if (fail_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  // One bus transfer; a read notes its expected byte
  task automatic bus(input logic we, input logic [15:0] idx,
    input logic [7:0] wd, input logic [7:0] exp);
    logic [31:0] r;
    r = $random(seed);
    if (!we)
      exp_q.push_back(exp);
    avs_address <= {idx[13:0], 2'b00};
    avs_writedata <= {r[31:8], wd};
    avs_byteenable <= {r[3:1], 1'b1};
    avs_read <= !we;
    avs_write <= we;
    // Waitrequest looked at on rising edges only; release after the answer
    do
      @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Read answers at the edge where waitrequest is low, oldest note first
  always @(posedge clk_sys)
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
    begin
      if (exp_q.size() == 0)
        chk("read queue", 32'h1, 32'h0);
      else
        chk("readdata", avs_readdata, {24'h0, exp_q.pop_front()});
    end

  function automatic occg_pkg::occg_gates_t gexp(input logic [7:0] a, b, c, d);
    return occg_pkg::occg_gates_t'({a[6], a[5], a[0], b[5], b[4], b[3], c[4],
      d[7], d[5], d[3], d[0]});
  endfunction

  // Main sequence
  initial
  begin
    logic [7:0] v;
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    for (int i = 0; i < 4; i++)
      bus(1'b0, idx_t[i], 8'h0, rst_t[i]);
    bus(1'b0, OSC, 8'h0, 8'h00);
    bus(1'b0, 16'h3010, 8'h0, 8'h00);
    for (int k = 0; k < 10; k++)
    begin
      for (int i = 0; i < 4; i++)
      begin
        v = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'($random(seed));
        // No peripheral runs here, so gating off or on needs no preparation
        bus(1'b1, idx_t[i], v, 8'h0);
        reg_v[i] = v & rst_t[i];
        bus(1'b0, idx_t[i], 8'h0, reg_v[i]);
      end
      repeat (3) @(posedge clk_sys);
      chk("gates", 32'(gates), 32'(gexp(reg_v[0], reg_v[1], reg_v[2],
        reg_v[3])));
    end
    bus(1'b1, OSC, 8'h76, 8'h0);
    bus(1'b0, OSC, 8'h0, 8'h36);
    repeat (3) @(posedge clk_sys);
    chk("osc_ctrl", 32'(osc_ctrl), 32'h7);
    chk("osc_running", 32'(osc_running), 32'h0);
    bus(1'b1, OSC, 8'hb4, 8'h0);
    repeat (3) @(posedge clk_sys);
    chk("osc_ctrl", 32'(osc_ctrl), 32'he);
    repeat (60) @(posedge clk_sys);
    bus(1'b0, OSC, 8'h0, 8'hb5);
    bus(1'b1, OSC, 8'h86, 8'h0);
    repeat (60) @(posedge clk_sys);
    bus(1'b0, OSC, 8'h0, 8'h87);
    stop_mode <= 1'b1;
    repeat (5) @(posedge clk_sys);
    chk("osc_running", 32'(osc_running), 32'h0);
    bus(1'b0, OSC, 8'h0, 8'h86);
    stop_mode <= 1'b0;
    bus(1'b1, OSC, 8'ha6, 8'h0);
    stop_mode <= 1'b1;
    repeat (5) @(posedge clk_sys);
    chk("osc_running", 32'(osc_running), 32'h1);
    stop_mode <= 1'b0;
    bus(1'b1, OSC, 8'h26, 8'h0);
    repeat (3) @(posedge clk_sys);
    chk("osc_running", 32'(osc_running), 32'h0);
    chk("ext_ref_clock_out", 32'(ext_ref_clock_out), 32'h0);
    clock_unit_osc_request <= 1'b1;
    repeat (3) @(posedge clk_sys);
    stop_mode <= 1'b1;
    repeat (5) @(posedge clk_sys);
    chk("osc_running", 32'(osc_running), 32'h1);
    clock_unit_osc_request <= 1'b0;
    stop_mode <= 1'b0;
    repeat (5) @(posedge clk_sys);
    chk("osc_running", 32'(osc_running), 32'h0);
    conclude();
  end
endmodule
